/* File: hw/urx_pkg.sv */
// Constants for the receive data and error status block.
// Assumes a 100 MHz system clock and a word-wide AHB-Lite register bus.
package urx_pkg;
    // ========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_DATA  = 12'h000;
    localparam logic [11:0] OFS_RSR   = 12'h004;
    localparam logic [11:0] OFS_LCTL  = 12'h02C;
    localparam logic [11:0] OFS_IMASK = 12'h038;
    localparam logic [11:0] OFS_ISTAT = 12'h03C;

    // ========================================================
    // Field positions
    localparam int FLAG_LSB = 8;   // Flags sit just above data byte
    localparam int LCTL_PEN = 1;
    localparam int LCTL_EPS = 2;
    localparam int LCTL_SPS = 7;
    localparam int INT_RX   = 0;
    localparam int INT_OE   = 1;
    localparam int INT_BRK  = 2;
    localparam int INT_ERR  = 3;

    // ========================================================
    // Reset values
    localparam logic [3:0] RSR_RST   = 4'h0;
    localparam logic [7:0] LCTL_RST  = 8'h00;
    localparam logic [3:0] IMASK_RST = 4'h0;
    localparam logic [3:0] ISTAT_RST = 4'h0;

    // ========================================================
    // Timing and sizes
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS   = 8680;
    localparam int CLKS_PER_BIT  = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH    = 16;

    // ========================================================
    // State encodings
    typedef enum logic [6:0] {
        RX_IDLE   = 7'b0000001,
        RX_START  = 7'b0000010,
        RX_DATA   = 7'b0000100,
        RX_PAR    = 7'b0001000,
        RX_STOP   = 7'b0010000,
        RX_BRKCHK = 7'b0100000,
        RX_BRKW   = 7'b1000000
    } urx_rx_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WAIT = 2'b10
    } urx_bus_e;
endpackage

/* File: hw/urx_core.sv */
// Receive path, error flags and data port of a serial port.
// Assumes rxd is already synchronous to hclk and an AHB-Lite master.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
// What this block does
// RULE_01: Data write sends low byte; read gives oldest byte with four flags.
// RULE_02: Stop bit sampled low sets framing flag, bit 8 of the word. Code: a break character gets the break flag, bit 10, instead.
// RULE_03: Break, parity and framing flags travel with their own character.
// RULE_04: A break pushes one zero character with break flag, no more.
// RULE_05: After break, wait for line high and a fresh start bit.
// RULE_06: Status register shows overrun, break, parity, framing in bits 3..0.
// RULE_07: Status break, parity, framing follow last character read from data.
// RULE_08: Status overrun sets at once when the overrun happens.
// RULE_09: Any write to the status address clears all four flags.
// RULE_10: Status register is zero after reset.
// RULE_11: Character completing while FIFO full sets overrun.
// RULE_12: Overrun leaves FIFO contents intact; only the shifter is lost.
// RULE_13: Line low beyond a full character time is a break.
// RULE_14: Parity flag when parity bit disagrees with line control choice.
// RULE_15: Flag bits of data register are read only; unused bits read 0.
// RULE_16: Data read of non-empty FIFO pops byte and flags together.
module urx_core #(
    parameter int DEPTH        = urx_pkg::FIFO_DEPTH,
    parameter int CLKS_PER_BIT = urx_pkg::CLKS_PER_BIT
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Serial receive line
    input  wire logic        rxd,
    // Transmit FIFO input
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // Interrupt
    output logic             irq
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [15:0] HALF = 16'(CLKS_PER_BIT / 2);
    localparam logic [15:0] LAST = 16'(CLKS_PER_BIT - 1);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

    // Expected parity bit for a byte under the line settings
    function automatic logic exp_par(input logic [7:0] d,
                                     input logic [7:0] lc);
        if (lc[urx_pkg::LCTL_SPS])
            exp_par = !lc[urx_pkg::LCTL_EPS];
        else
            exp_par = lc[urx_pkg::LCTL_EPS] ? ^d : !(^d);
    endfunction

    // ========================================================
    // Receive shifter
    urx_pkg::urx_rx_e rx_reg, rx_next;
    logic [15:0]      tick_reg, tick_next;
    logic [2:0]       idx_reg, idx_next;
    logic [7:0]       sh_reg, sh_next;
    logic             par_reg, par_next;
    logic             low_reg, low_next;
    logic             push, brk_ev, err_ev;
    logic [11:0]      word;
    logic [7:0]       lctl_reg, lctl_next;
    logic             pend_oe_reg, pend_oe_next;

    // Bit timing samples at mid-bit; break check adds half a bit
    always_comb
    begin
        rx_next   = rx_reg;
        tick_next = tick_reg + 16'h0001;
        idx_next  = idx_reg;
        sh_next   = sh_reg;
        par_next  = par_reg;
        low_next  = low_reg;
        push      = 1'b0;
        brk_ev    = 1'b0;
        err_ev    = 1'b0;
        word      = 12'h000;
        case (rx_reg)
            urx_pkg::RX_IDLE:
            begin
                tick_next = 16'h0000;
                if (!rxd)
                    rx_next = urx_pkg::RX_START;
            end
            urx_pkg::RX_START:
                if (tick_reg == HALF)
                begin
                    tick_next = 16'h0000;
                    idx_next  = 3'h0;
                    low_next  = 1'b1;
                    rx_next   = rxd ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
                end
            urx_pkg::RX_DATA:
                if (tick_reg == LAST)
                begin
                    tick_next = 16'h0000;
                    sh_next   = {rxd, sh_reg[7:1]};
                    low_next  = low_reg & !rxd;
                    idx_next  = idx_reg + 3'h1;
                    if (idx_reg == 3'h7)
                        rx_next = lctl_reg[urx_pkg::LCTL_PEN] ?
                                  urx_pkg::RX_PAR : urx_pkg::RX_STOP;
                end
            urx_pkg::RX_PAR:
                if (tick_reg == LAST)
                begin
                    tick_next = 16'h0000;
                    par_next  = rxd;
                    low_next  = low_reg & !rxd;
                    rx_next   = urx_pkg::RX_STOP;
                end
            urx_pkg::RX_STOP:
                if (tick_reg == LAST)
                begin
                    tick_next = 16'h0000;
                    if (rxd || !low_reg)
                    begin
                        // Flags bound to this character
                        push    = 1'b1; // RULE_03
                        word[9] = lctl_reg[urx_pkg::LCTL_PEN] &&
                                  (par_reg != exp_par(sh_reg, lctl_reg)); // RULE_14
                        word[8] = !rxd; // RULE_02
                        word[7:0] = sh_reg;
                        err_ev  = word[9] | word[8];
                        rx_next = urx_pkg::RX_IDLE;
                    end
                    else
                        rx_next = urx_pkg::RX_BRKCHK;
                end
            urx_pkg::RX_BRKCHK:
                if (rxd)
                begin
                    // Line rose before a full character time
                    push    = 1'b1;
                    word[8] = 1'b1; // RULE_02
                    err_ev  = 1'b1;
                    rx_next = urx_pkg::RX_IDLE;
                end
                else if (tick_reg == HALF)
                begin
                    push    = 1'b1; // RULE_13
                    word[10] = 1'b1; // RULE_04
                    brk_ev  = 1'b1;
                    rx_next = urx_pkg::RX_BRKW;
                end
            urx_pkg::RX_BRKW:
                if (rxd)
                    rx_next = urx_pkg::RX_IDLE; // RULE_05
            default:
                rx_next = urx_pkg::RX_IDLE;
        endcase
        word[11] = push & pend_oe_reg;
    end

    // Receive shifter registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_reg   <= urx_pkg::RX_IDLE;
            tick_reg <= 16'h0000;
            idx_reg  <= 3'h0;
            sh_reg   <= 8'h00;
            par_reg  <= 1'b0;
            low_reg  <= 1'b0;
        end
        else
        begin
            rx_reg   <= rx_next;
            tick_reg <= tick_next;
            idx_reg  <= idx_next;
            sh_reg   <= sh_next;
            par_reg  <= par_next;
            low_reg  <= low_next;
        end
    end

    // ========================================================
    // Receive FIFO, 12 bits: overrun, break, parity, framing, data
    logic [11:0]   mem_reg [DEPTH];
    logic [11:0]   mem_next [DEPTH];
    logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [PW:0]   cnt_reg, cnt_next;
    logic          pop, full, ovr_ev, wr_en;

    // Full FIFO refuses the push so stored entries survive
    always_comb
    begin
        full     = (cnt_reg == FULL);
        wr_en    = push && !full;
        ovr_ev   = push && full; // RULE_11
        mem_next = mem_reg;
        if (wr_en)
            mem_next[wp_reg] = word; // RULE_12
        wp_next  = wr_en ? wp_reg + 1'b1 : wp_reg;
        rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (PW + 1)'(wr_en) - (PW + 1)'(pop);
        pend_oe_next = wr_en ? 1'b0 : (pend_oe_reg | ovr_ev);
    end

    // FIFO storage; DEPTH must be a power of two
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= 12'h000;
            wp_reg      <= '0;
            rp_reg      <= '0;
            cnt_reg     <= '0;
            pend_oe_reg <= 1'b0;
        end
        else
        begin
            mem_reg     <= mem_next;
            wp_reg      <= wp_next;
            rp_reg      <= rp_next;
            cnt_reg     <= cnt_next;
            pend_oe_reg <= pend_oe_next;
        end
    end

    // ========================================================
    // Bus slave and registers
    urx_pkg::urx_bus_e bus_reg, bus_next;
    logic [11:0] adr_reg, adr_next;
    logic        wr_reg, wr_next;
    logic [31:0] hrd_next;
    logic        hrdy_next, txv_next, irq_next;
    logic [7:0]  txd_next;
    logic [3:0]  rsr_reg, rsr_next;
    logic [3:0]  imask_reg, imask_next, ist_reg, ist_next;
    logic [11:0] head;

    // Every transfer takes at least one wait state so read data leave a flop
    always_comb
    begin
        head       = mem_reg[rp_reg];
        bus_next   = bus_reg;
        adr_next   = adr_reg;
        wr_next    = wr_reg;
        hrd_next   = hrdata;
        hrdy_next  = hreadyout;
        txv_next   = tx_valid && !tx_ready;
        txd_next   = tx_data;
        rsr_next   = rsr_reg;
        lctl_next  = lctl_reg;
        imask_next = imask_reg;
        ist_next   = ist_reg;
        pop        = 1'b0;
        case (bus_reg)
            urx_pkg::BUS_IDLE:
                if (hsel && hready && htrans[1])
                begin
                    adr_next  = haddr[11:0];
                    wr_next   = hwrite;
                    bus_next  = urx_pkg::BUS_WAIT;
                    hrdy_next = 1'b0;
                end
            urx_pkg::BUS_WAIT:
                // Stall a data write while the last byte is unaccepted
                if (!(wr_reg && adr_reg == urx_pkg::OFS_DATA && txv_next))
                begin
                    bus_next  = urx_pkg::BUS_IDLE;
                    hrdy_next = 1'b1;
                    hrd_next  = 32'h0000_0000; // RULE_15
                    if (wr_reg)
                    begin
                        if (adr_reg == urx_pkg::OFS_DATA)
                        begin
                            txd_next = hwdata[7:0]; // RULE_01
                            txv_next = 1'b1;
                        end
                        else if (adr_reg == urx_pkg::OFS_RSR)
                            rsr_next = 4'h0; // RULE_09
                        else if (adr_reg == urx_pkg::OFS_LCTL)
                            lctl_next = hwdata[7:0];
                        else if (adr_reg == urx_pkg::OFS_IMASK)
                            imask_next = hwdata[3:0];
                        else if (adr_reg == urx_pkg::OFS_ISTAT)
                            ist_next = ist_reg & ~hwdata[3:0];
                    end
                    else if (adr_reg == urx_pkg::OFS_DATA)
                    begin
                        if (cnt_reg != '0)
                        begin
                            pop      = 1'b1; // RULE_16
                            hrd_next = {20'h00000, head}; // RULE_01
                            rsr_next[2:0] = head[10:8]; // RULE_07
                        end
                    end
                    else if (adr_reg == urx_pkg::OFS_RSR)
                        hrd_next = {28'h0000000, rsr_reg}; // RULE_06
                    else if (adr_reg == urx_pkg::OFS_LCTL)
                        hrd_next = {24'h000000, lctl_reg};
                    else if (adr_reg == urx_pkg::OFS_IMASK)
                        hrd_next = {28'h0000000, imask_reg};
                    else if (adr_reg == urx_pkg::OFS_ISTAT)
                        hrd_next = {28'h0000000, ist_reg};
                end
            default:
                bus_next = urx_pkg::BUS_IDLE;
        endcase
        // Hardware events win over a clear in the same cycle
        if (ovr_ev)
            rsr_next[3] = 1'b1; // RULE_08
        ist_next[urx_pkg::INT_RX]  = ist_next[urx_pkg::INT_RX] | wr_en;
        ist_next[urx_pkg::INT_OE]  = ist_next[urx_pkg::INT_OE] | ovr_ev;
        ist_next[urx_pkg::INT_BRK] = ist_next[urx_pkg::INT_BRK] | brk_ev;
        ist_next[urx_pkg::INT_ERR] = ist_next[urx_pkg::INT_ERR] | err_ev;
        irq_next = |(ist_next & imask_next);
    end

    // Bus and register flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_reg   <= urx_pkg::BUS_IDLE;
            adr_reg   <= 12'h000;
            wr_reg    <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            tx_valid  <= 1'b0;
            tx_data   <= 8'h00;
            rsr_reg   <= urx_pkg::RSR_RST; // RULE_10
            lctl_reg  <= urx_pkg::LCTL_RST;
            imask_reg <= urx_pkg::IMASK_RST;
            ist_reg   <= urx_pkg::ISTAT_RST;
            irq       <= 1'b0;
        end
        else
        begin
            bus_reg   <= bus_next;
            adr_reg   <= adr_next;
            wr_reg    <= wr_next;
            hrdata    <= hrd_next;
            hreadyout <= hrdy_next;
            hresp     <= 1'b0; // Always OKAY
            tx_valid  <= txv_next;
            tx_data   <= txd_next;
            rsr_reg   <= rsr_next;
            lctl_reg  <= lctl_next;
            imask_reg <= imask_next;
            ist_reg   <= ist_next;
            irq       <= irq_next;
        end
    end

    // ========================================================
    // Checks
    chk_rsr_reset: assert property (@(posedge hclk) // RULE_10
        $rose(hresetn) |-> rsr_reg == 4'h0)
        else $error("status not zero after reset");
    chk_ovr_immediate: assert property (@(posedge hclk) // RULE_08
        disable iff (!hresetn) push && full |=> rsr_reg[3])
        else $error("overrun flag late");
    chk_fifo_keep: assert property (@(posedge hclk) // RULE_12
        disable iff (!hresetn) push && full && !pop
        |=> cnt_reg == FULL && $stable(wp_reg))
        else $error("fifo changed on overrun");
    chk_ecr_clear: assert property (@(posedge hclk) // RULE_09
        disable iff (!hresetn) bus_reg == urx_pkg::BUS_WAIT && wr_reg
        && adr_reg == urx_pkg::OFS_RSR && !ovr_ev
        |=> rsr_reg == 4'h0)
        else $error("error clear failed");
    chk_break_char: assert property (@(posedge hclk) // RULE_04
        disable iff (!hresetn) brk_ev |-> word[10:0] == 11'h400
        ##1 (!push && rx_reg == urx_pkg::RX_BRKW) ##1 !push)
        else $error("break character wrong");
    chk_frame_flag: assert property (@(posedge hclk) // RULE_02
        disable iff (!hresetn) rx_reg == urx_pkg::RX_STOP
        && tick_reg == LAST && !rxd && !low_reg |-> push && word[8])
        else $error("framing flag missing");
    chk_dr_pop: assert property (@(posedge hclk) // RULE_16
        disable iff (!hresetn) pop && !wr_en
        |=> cnt_reg == $past(cnt_reg) - 1'b1
        && hrdata[11:0] == $past(head))
        else $error("data read did not pop head");
    chk_rsr_follows: assert property (@(posedge hclk) // RULE_07
        disable iff (!hresetn) pop
        |=> rsr_reg[2:0] == $past(head[10:8]))
        else $error("status flags not from last read");
    chk_tx_write: assert property (@(posedge hclk) // RULE_01
        disable iff (!hresetn) bus_reg == urx_pkg::BUS_WAIT
        && bus_next == urx_pkg::BUS_IDLE && wr_reg
        && adr_reg == urx_pkg::OFS_DATA
        |=> tx_valid && tx_data == $past(hwdata[7:0]))
        else $error("transmit byte not queued");
    chk_brk_hold: assert property (@(posedge hclk) // RULE_05
        disable iff (!hresetn) rx_reg == urx_pkg::RX_BRKW && !rxd
        |=> rx_reg == urx_pkg::RX_BRKW)
        else $error("left break wait while low");
endmodule

/* File: tb/urx_far_end.sv */
// Far-end serial transmitter that drives the receive line of the block.
// Assumes one bit lasts CPB cycles of hclk and the line idles high.
`timescale 1ns/1ns
module urx_far_end #(
    parameter int CPB = 8
) (
    // Clock used only to time the bits
    input  wire logic hclk,
    // Serial line towards the block
    output logic      rxd
);
    // ========================================================
    // Line level
    // Idle high from time zero, like a marking line with pull-up
    initial
    begin
        rxd = 1'b1;
    end

    // ========================================================
    // Frame tasks
    // One bit time at a given level, changed just after an edge
    task automatic line_bit(input logic v);
        rxd <= v;
        repeat (CPB) @(posedge hclk);
    endtask

    // Start, eight data bits LSB first, optional parity, stop, idle
    task automatic send(input logic [7:0] d, input logic pe,
                        input logic pv, input logic sv);
        @(posedge hclk);
        line_bit(1'b0);
        for (int i = 0; i < 8; i++)
            line_bit(d[i]);
        if (pe)
            line_bit(pv);
        line_bit(sv);
        // Two idle bits so a late stop check sees the line high
        line_bit(1'b1);
        line_bit(1'b1);
    endtask

    // Line held low for n bit times, then back to marking
    task automatic brk(input int n);
        @(posedge hclk);
        repeat (n) line_bit(1'b0);
        line_bit(1'b1);
        line_bit(1'b1);
    endtask
endmodule

/* File: tb/test_uart_rx_data_error_status.sv */
// Self-checking bench for the receive data and error status block.
// Assumes urx_pkg, urx_core and the far-end model urx_far_end.
`timescale 1ns/1ns
module test_uart_rx_data_error_status;
    // ========================================================
    // Sizes and addresses
    localparam int CPB = 8;     // Short bit time keeps the run brief
    localparam int DEP = 4;     // Small FIFO so overrun comes quickly
    localparam logic [11:0] DAT = urx_pkg::OFS_DATA;
    localparam logic [11:0] RSR = urx_pkg::OFS_RSR;
    localparam logic [11:0] LC  = urx_pkg::OFS_LCTL;
    localparam logic [11:0] IM  = urx_pkg::OFS_IMASK;
    localparam logic [11:0] IS  = urx_pkg::OFS_ISTAT;

    // ========================================================
    // Signals and bookkeeping
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        rxd, tx_valid, tx_ready, irq, p, in_rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  tx_data, b;
    logic [31:0] rd_q[$];
    logic [7:0]  tx_q[$];
    logic [7:0]  ov[DEP+1];
    logic [7:0]  lc[4] = '{8'h02, 8'h06, 8'h82, 8'h86};
    int          fails, compares;

    // Clock of 100 MHz
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    urx_core #(.DEPTH(DEP), .CLKS_PER_BIT(CPB)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .irq(irq)
    );

    urx_far_end #(.CPB(CPB)) far (.hclk(hclk), .rxd(rxd));

    // ========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Single word transfer; waits on the slave, never on a fixed count
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // Expected value is noted first, the watcher compares it later
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Two edges let the registered interrupt settle
    task automatic irq_is(input logic v);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, {31'h0, v});
    endtask

    task automatic summarize();
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ========================================================
    // Result watcher for read data and bytes sent to transmit
    always @(posedge hclk)
    begin
        if (in_rd && hreadyout === 1'b1)
        begin
            chk(hrdata, rd_q.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
        if (hreadyout === 1'b1)
            in_rd = hsel && htrans[1] && !hwrite;
        if (tx_valid === 1'b1 && tx_ready)
            chk({24'h0, tx_data}, {24'h0, tx_q.pop_front()});
    end

    // Transmit side mostly stalls so back-to-back data writes must wait
    always @(posedge hclk)
        tx_ready <= ($urandom % 4) == 0;

    // Hang guard, far beyond the few thousand cycles the tests need
    initial
    begin
        repeat (40000) @(posedge hclk);
        fails++;
        summarize();
    end

    // ========================================================
    // Main sequence
    initial
    begin
        hresetn  = 1'b0;
        hsel     = 1'b0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        haddr    = 32'h0;
        hwdata   = 32'h0;
        tx_ready = 1'b0;
        in_rd    = 1'b0;
        fails    = 0;
        compares = 0;
        void'($urandom(32'h300a1fae));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(RSR, 32'h0);
        rd(DAT, 32'h0);
        rd(12'h100, 32'h0);
        wr(12'h100, 32'hFFFF_FFFF);
        repeat (4)
        begin
            b = 8'($urandom);
            tx_q.push_back(b);
            wr(DAT, {24'hFF_FFFF, b});
        end
        rd(DAT, 32'h0);
        // Every parity mode, one good and one bad character each
        foreach (lc[i])
        begin
            wr(LC, {24'h0, lc[i]});
            b = 8'($urandom);
            p = lc[i][7] ? !lc[i][2] : (lc[i][2] ? ^b : ~^b);
            far.send(b, 1'b1, p, 1'b1);
            rd(DAT, {24'h0, b});
            far.send(b, 1'b1, !p, 1'b1);
            rd(DAT, {20'h0, 4'h2, b});
            rd(RSR, 32'h2);
            wr(RSR, $urandom);
            rd(RSR, 32'h0);
        end
        // Bad stop bit on a non-zero character
        wr(LC, 32'h0);
        b = 8'($urandom) | 8'h01;
        far.send(b, 1'b0, 1'b0, 1'b0);
        rd(DAT, {20'h0, 4'h1, b});
        rd(RSR, 32'h1);
        // Long break, then a fresh character
        far.brk(30);
        b = 8'($urandom);
        far.send(b, 1'b0, 1'b0, 1'b1);
        rd(DAT, 32'h400);
        rd(RSR, 32'h4);
        rd(DAT, {24'h0, b});
        rd(RSR, 32'h0);
        rd(DAT, 32'h0);
        // One character more than the FIFO holds
        foreach (ov[i])
        begin
            ov[i] = 8'($urandom);
            far.send(ov[i], 1'b0, 1'b0, 1'b1);
        end
        rd(RSR, 32'h8);
        for (int i = 0; i < DEP; i++)
            rd(DAT, {24'h0, ov[i]});
        b = 8'($urandom);
        far.send(b, 1'b0, 1'b0, 1'b1);
        rd(DAT, {20'h0, 4'h8, b});
        wr(RSR, 32'h0);
        rd(RSR, 32'h0);
        // Interrupt raised, masked, unmasked and cleared
        wr(IS, 32'hF);
        wr(IM, 32'h1);
        irq_is(1'b0);
        far.send(b, 1'b0, 1'b0, 1'b1);
        irq_is(1'b1);
        wr(IM, 32'h0);
        irq_is(1'b0);
        wr(IM, 32'h1);
        irq_is(1'b1);
        wr(IS, 32'h1);
        irq_is(1'b0);
        rd(IM, 32'h1);
        rd(DAT, {24'h0, b});
        repeat (4) @(posedge hclk);
        chk(tx_q.size(), 0);
        summarize();
    end
endmodule
